// [logic/tapdec_top.sv]
// tapdec_top: test access port controller with instruction decode and boundary scan cells
// assumes: tck_in is a free clock from the test controller; tms_in and tdi_in are timed to it;
// pin_state_in comes from the memory clock domain; rst_in is the power-up reset on sys_clk_in
//
// Operation
// - capture-IR loads 01 into low bits
// - shift-IR puts instruction register in path
// - new instruction acts only at update-IR
// - code 111 selects one-bit bypass register
// - code 100 capture-DR loads pins, defaults
// - sample/preload shift-DR uses boundary register
// - code 000 selects extest, boundary register
// - extest never blocks functional input pins
// - extest drives scan cells onto outputs
// - extest capture-DR loads pins, defaults, as sample does
// - code 001 captures and shifts identification
// - identification active at power-up and reset
// - code 010 forces outputs high impedance
// - codes 011, 110 behave as bypass
// - codes read with leftmost bit most significant
// - instruction register three bits, loads in path
// - five high mode-select edges reach reset
// - sample on rising, output on falling edge
// - identification 32 bits, bit 0 first out
`timescale 1ns/1ps

module tapdec_top #(
    parameter int BSR_W = 16,                  // boundary scan cells
    parameter int PIN_W = 12,                  // cells fed from input and I/O pins
    parameter int OUT_W = 8,                   // cells that drive output pins
    parameter logic [31:0] ID_CODE = 32'h0000_0001 // arbitrary identification value
)(
    // system side
    input wire logic sys_clk_in,
    input wire logic rst_in,
    // test link
    input wire logic tck_in,
    input wire logic tms_in,
    input wire logic tdi_in,
    output logic tdo_out,
    output logic tdo_oe_n_out,
    // memory pins
    input wire logic [PIN_W-1:0] pin_state_in,
    output logic mem_hiz_out,
    output logic mem_drive_out,
    output logic [OUT_W-1:0] mem_value_out
);

    // ********************************
    // elaboration checks
    // ********************************
    // at least one pinless cell must sit at the top of the chain, since its default is checked there
    if (PIN_W >= BSR_W || OUT_W > BSR_W || PIN_W < 1 || OUT_W < 1)
    begin : g_bad_width
        $error("tapdec_top: pin or output cells exceed boundary register");
    end

    // ********************************
    // functions
    // ********************************
    // instruction to data register; codes are plain binary, msb leftmost
    function automatic tapdec_pkg::tapdec_sel_t decode(input logic [tapdec_pkg::IR_W-1:0] code);
        unique case (code)
            tapdec_pkg::CODE_EXTEST: decode = tapdec_pkg::TAPDEC_SEL_BSR;
            tapdec_pkg::CODE_IDCODE: decode = tapdec_pkg::TAPDEC_SEL_ID;
            tapdec_pkg::CODE_SAMPLE_Z: decode = tapdec_pkg::TAPDEC_SEL_BSR;
            tapdec_pkg::CODE_SAMPLE: decode = tapdec_pkg::TAPDEC_SEL_BSR;
            tapdec_pkg::CODE_RESERVED_A: decode = tapdec_pkg::TAPDEC_SEL_BYPASS;
            tapdec_pkg::CODE_RESERVED_B: decode = tapdec_pkg::TAPDEC_SEL_BYPASS;
            tapdec_pkg::CODE_PRIVATE: decode = tapdec_pkg::TAPDEC_SEL_BYPASS;
            tapdec_pkg::CODE_BYPASS: decode = tapdec_pkg::TAPDEC_SEL_BYPASS;
        endcase
    endfunction

    // controller transition on one rising test-clock edge
    function automatic tapdec_pkg::tapdec_state_t step(input tapdec_pkg::tapdec_state_t s, input logic m);
        unique case (s)
            tapdec_pkg::TAPDEC_RESET: step = m ? tapdec_pkg::TAPDEC_RESET : tapdec_pkg::TAPDEC_IDLE;
            tapdec_pkg::TAPDEC_IDLE: step = m ? tapdec_pkg::TAPDEC_SEL_DR : tapdec_pkg::TAPDEC_IDLE;
            tapdec_pkg::TAPDEC_SEL_DR: step = m ? tapdec_pkg::TAPDEC_SEL_IR : tapdec_pkg::TAPDEC_CAP_DR;
            tapdec_pkg::TAPDEC_CAP_DR: step = m ? tapdec_pkg::TAPDEC_EXIT1_DR : tapdec_pkg::TAPDEC_SHIFT_DR;
            tapdec_pkg::TAPDEC_SHIFT_DR: step = m ? tapdec_pkg::TAPDEC_EXIT1_DR : tapdec_pkg::TAPDEC_SHIFT_DR;
            tapdec_pkg::TAPDEC_EXIT1_DR: step = m ? tapdec_pkg::TAPDEC_UPD_DR : tapdec_pkg::TAPDEC_PAUSE_DR;
            tapdec_pkg::TAPDEC_PAUSE_DR: step = m ? tapdec_pkg::TAPDEC_EXIT2_DR : tapdec_pkg::TAPDEC_PAUSE_DR;
            tapdec_pkg::TAPDEC_EXIT2_DR: step = m ? tapdec_pkg::TAPDEC_UPD_DR : tapdec_pkg::TAPDEC_SHIFT_DR;
            tapdec_pkg::TAPDEC_UPD_DR: step = m ? tapdec_pkg::TAPDEC_SEL_DR : tapdec_pkg::TAPDEC_IDLE;
            tapdec_pkg::TAPDEC_SEL_IR: step = m ? tapdec_pkg::TAPDEC_RESET : tapdec_pkg::TAPDEC_CAP_IR;
            tapdec_pkg::TAPDEC_CAP_IR: step = m ? tapdec_pkg::TAPDEC_EXIT1_IR : tapdec_pkg::TAPDEC_SHIFT_IR;
            tapdec_pkg::TAPDEC_SHIFT_IR: step = m ? tapdec_pkg::TAPDEC_EXIT1_IR : tapdec_pkg::TAPDEC_SHIFT_IR;
            tapdec_pkg::TAPDEC_EXIT1_IR: step = m ? tapdec_pkg::TAPDEC_UPD_IR : tapdec_pkg::TAPDEC_PAUSE_IR;
            tapdec_pkg::TAPDEC_PAUSE_IR: step = m ? tapdec_pkg::TAPDEC_EXIT2_IR : tapdec_pkg::TAPDEC_PAUSE_IR;
            tapdec_pkg::TAPDEC_EXIT2_IR: step = m ? tapdec_pkg::TAPDEC_UPD_IR : tapdec_pkg::TAPDEC_SHIFT_IR;
            tapdec_pkg::TAPDEC_UPD_IR: step = m ? tapdec_pkg::TAPDEC_SEL_DR : tapdec_pkg::TAPDEC_IDLE;
        endcase
    endfunction

    // ********************************
    // test clock domain: reset and pin crossing
    // ********************************
    logic rst_meta; // first stage of power-up reset into test domain
    logic rst_tap; // test domain reset
    logic [PIN_W-1:0] pin_meta; // first stage of pin crossing
    logic [PIN_W-1:0] pin_sync; // pin levels usable by capture

    // power-up reset; the link has no reset pin of its own, so rst_in is carried over
    always_ff @(posedge tck_in)
    begin
        rst_meta <= rst_in;
        rst_tap <= rst_meta;
    end

    // pins change on the memory clock; capture is only repeatable if the party holds them still
    always_ff @(posedge tck_in)
    begin
        pin_meta <= pin_state_in;
        pin_sync <= pin_meta;
    end

    // ********************************
    // controller state
    // ********************************
    tapdec_pkg::tapdec_state_t state; // controller state

    // mode select sampled on the rising edge; held high walks to reset in at most five edges
    always_ff @(posedge tck_in)
    begin
        if (rst_tap)
        begin
            state <= tapdec_pkg::TAPDEC_RESET;
        end
        else
        begin
            state <= step(state, tms_in);
        end
    end

    // ********************************
    // instruction register
    // ********************************
    logic [tapdec_pkg::IR_W-1:0] ir_shift; // serial instruction stage
    logic [tapdec_pkg::IR_W-1:0] ir_active; // instruction in force
    tapdec_pkg::tapdec_sel_t sel; // data register picked by the active code

    assign sel = decode(ir_active);

    // capture pattern then shift; loaded only while it sits in the serial path
    always_ff @(posedge tck_in)
    begin
        if (rst_tap)
        begin
            ir_shift <= tapdec_pkg::CODE_IDCODE;
        end
        else if (state == tapdec_pkg::TAPDEC_CAP_IR)
        begin
            ir_shift <= {ir_shift[tapdec_pkg::IR_W-1:2], tapdec_pkg::IR_CAPTURE};
        end
        else if (state == tapdec_pkg::TAPDEC_SHIFT_IR)
        begin
            ir_shift <= {tdi_in, ir_shift[tapdec_pkg::IR_W-1:1]};
        end
    end

    // ********************************
    // data registers
    // ********************************
    logic bypass; // one-bit bypass cell
    logic [tapdec_pkg::ID_W-1:0] id_shift; // identification shift stage
    logic [BSR_W-1:0] bsr; // boundary scan shift stage
    logic [BSR_W-1:0] bsr_capture; // parallel capture value

    // pin cells first, pinless cells hold their fixed default
    always_comb
    begin
        bsr_capture = {BSR_W{tapdec_pkg::CELL_DEFAULT}};
        bsr_capture[PIN_W-1:0] = pin_sync;
    end

    // bypass cell: zero on capture, one stage of delay while shifting
    always_ff @(posedge tck_in)
    begin
        if (state == tapdec_pkg::TAPDEC_CAP_DR && sel == tapdec_pkg::TAPDEC_SEL_BYPASS)
        begin
            bypass <= tapdec_pkg::BYPASS_CAPTURE;
        end
        else if (state == tapdec_pkg::TAPDEC_SHIFT_DR && sel == tapdec_pkg::TAPDEC_SEL_BYPASS)
        begin
            bypass <= tdi_in;
        end
    end

    // identification: rom value on capture, bit 0 leaves first
    always_ff @(posedge tck_in)
    begin
        if (state == tapdec_pkg::TAPDEC_CAP_DR && sel == tapdec_pkg::TAPDEC_SEL_ID)
        begin
            id_shift <= ID_CODE;
        end
        else if (state == tapdec_pkg::TAPDEC_SHIFT_DR && sel == tapdec_pkg::TAPDEC_SEL_ID)
        begin
            id_shift <= {tdi_in, id_shift[tapdec_pkg::ID_W-1:1]};
        end
    end

    // boundary register: extest, sample and sample-z all capture and shift it
    always_ff @(posedge tck_in)
    begin
        if (state == tapdec_pkg::TAPDEC_CAP_DR && sel == tapdec_pkg::TAPDEC_SEL_BSR)
        begin
            bsr <= bsr_capture;
        end
        else if (state == tapdec_pkg::TAPDEC_SHIFT_DR && sel == tapdec_pkg::TAPDEC_SEL_BSR)
        begin
            bsr <= {tdi_in, bsr[BSR_W-1:1]};
        end
    end

    // ********************************
    // falling edge: instruction update, output latch, serial out
    // ********************************
    logic [OUT_W-1:0] upd; // parallel output latch of the boundary cells
    logic out_tog; // flips each time the memory-side word changes
    logic serial_bit; // bit presented to the serial output

    // serial path selection
    always_comb
    begin
        serial_bit = bypass;
        if (state == tapdec_pkg::TAPDEC_SHIFT_IR)
        begin
            serial_bit = ir_shift[0];
        end
        else if (sel == tapdec_pkg::TAPDEC_SEL_ID)
        begin
            serial_bit = id_shift[0];
        end
        else if (sel == tapdec_pkg::TAPDEC_SEL_BSR)
        begin
            serial_bit = bsr[0];
        end
    end

    // active instruction swaps only in update-IR; reset restores identification
    always_ff @(negedge tck_in)
    begin
        if (rst_tap || state == tapdec_pkg::TAPDEC_RESET)
        begin
            ir_active <= tapdec_pkg::CODE_IDCODE;
        end
        else if (state == tapdec_pkg::TAPDEC_UPD_IR)
        begin
            ir_active <= ir_shift;
        end
    end

    // output cells latched at update-IR as well as update-DR so extest drives fresh data
    always_ff @(negedge tck_in)
    begin
        if (rst_tap)
        begin
            upd <= '0;
            out_tog <= 1'h0;
        end
        else if (state == tapdec_pkg::TAPDEC_UPD_IR || state == tapdec_pkg::TAPDEC_UPD_DR)
        begin
            upd <= bsr[OUT_W-1:0];
            out_tog <= ~out_tog;
        end
        else if (state == tapdec_pkg::TAPDEC_RESET)
        begin
            out_tog <= ~out_tog; // publish the return to identification
        end
    end

    // serial output moves only on the falling edge and floats outside shift states
    always_ff @(negedge tck_in)
    begin
        if (rst_tap)
        begin
            tdo_out <= 1'h0;
            tdo_oe_n_out <= 1'h1;
        end
        else
        begin
            tdo_out <= serial_bit;
            tdo_oe_n_out <= !(state == tapdec_pkg::TAPDEC_SHIFT_IR || state == tapdec_pkg::TAPDEC_SHIFT_DR);
        end
    end

    // ********************************
    // system domain: memory-side controls
    // ********************************
    logic tog_meta; // first stage of toggle crossing
    logic tog_sync; // synchronised toggle
    logic tog_seen; // last toggle acted on

    // toggle handshake; the word it guards stays still for many fast-clock cycles
    always_ff @(posedge sys_clk_in)
    begin
        tog_meta <= out_tog;
        tog_sync <= tog_meta;
    end

    // take the word whenever the toggle moves; input pins are never overridden here
    always_ff @(posedge sys_clk_in)
    begin
        if (rst_in)
        begin
            tog_seen <= 1'h0;
            mem_hiz_out <= 1'h0;
            mem_drive_out <= 1'h0;
            mem_value_out <= '0;
        end
        else if (tog_sync != tog_seen)
        begin
            tog_seen <= tog_sync;
            mem_hiz_out <= (ir_active == tapdec_pkg::CODE_SAMPLE_Z);
            mem_drive_out <= (ir_active == tapdec_pkg::CODE_EXTEST);
            mem_value_out <= upd;
        end
    end

    // ********************************
    // checks
    // ********************************
    capture_ir_load_a: assert property (@(posedge tck_in) disable iff (rst_tap)
        state == tapdec_pkg::TAPDEC_CAP_IR |=> ir_shift[1:0] == tapdec_pkg::IR_CAPTURE)
        else $error("capture-IR pattern missing");

    ir_shift_path_a: assert property (@(posedge tck_in) disable iff (rst_tap)
        state == tapdec_pkg::TAPDEC_SHIFT_IR |=> ir_shift[tapdec_pkg::IR_W-1] == $past(tdi_in)
        && ir_shift[0] == $past(ir_shift[1]))
        else $error("instruction shift wrong");

    ir_hold_a: assert property (@(posedge tck_in) disable iff (rst_tap)
        ir_active != $past(ir_active) |-> state == tapdec_pkg::TAPDEC_UPD_IR
        || state == tapdec_pkg::TAPDEC_RESET)
        else $error("instruction changed outside update");

    bypass_shift_a: assert property (@(posedge tck_in) disable iff (rst_tap)
        state == tapdec_pkg::TAPDEC_SHIFT_DR && ir_active == tapdec_pkg::CODE_BYPASS
        |=> bypass == $past(tdi_in))
        else $error("bypass cell not in path");

    bsr_capture_a: assert property (@(posedge tck_in) disable iff (rst_tap)
        state == tapdec_pkg::TAPDEC_CAP_DR && ir_active == tapdec_pkg::CODE_SAMPLE
        |=> bsr[PIN_W-1:0] == $past(pin_sync) && bsr[BSR_W-1] == tapdec_pkg::CELL_DEFAULT)
        else $error("boundary capture wrong");

    id_capture_a: assert property (@(posedge tck_in) disable iff (rst_tap)
        state == tapdec_pkg::TAPDEC_CAP_DR && ir_active == tapdec_pkg::CODE_IDCODE |=> id_shift == ID_CODE)
        else $error("identification not captured");

    reset_ident_a: assert property (@(posedge tck_in) disable iff (rst_tap)
        state == tapdec_pkg::TAPDEC_RESET |=> ir_active == tapdec_pkg::CODE_IDCODE)
        else $error("identification not restored");

    tms_reset_a: assert property (@(posedge tck_in) disable iff (rst_tap)
        tms_in [*5] |=> state == tapdec_pkg::TAPDEC_RESET)
        else $error("five high mode edges missed reset");

    reserved_bypass_a: assert property (@(posedge tck_in) disable iff (rst_tap)
        state == tapdec_pkg::TAPDEC_CAP_DR && (ir_active == tapdec_pkg::CODE_RESERVED_A
        || ir_active == tapdec_pkg::CODE_RESERVED_B || ir_active == tapdec_pkg::CODE_PRIVATE)
        ##1 state == tapdec_pkg::TAPDEC_SHIFT_DR
        |-> tdo_oe_n_out == 1'h0 && tdo_out == tapdec_pkg::BYPASS_CAPTURE)
        else $error("reserved code not bypass");

    hiz_excl_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        !(mem_hiz_out && mem_drive_out))
        else $error("high impedance and extest drive together");

endmodule

// [logic/tapdec_pkg.sv]
// tapdec_pkg: shared constants and types for the test access port instruction decoder
// assumes: an external boundary-scan controller drives the test clock, mode select and data input
package tapdec_pkg;

    // ********************************
    // instruction register layout
    // ********************************
    localparam int IR_W = 3;                          // instruction width
    localparam logic [1:0] IR_CAPTURE = 2'h1;         // pattern for the two low bits on capture
    localparam logic [IR_W-1:0] CODE_EXTEST = 3'h0;   // drive scan cells onto outputs
    localparam logic [IR_W-1:0] CODE_IDCODE = 3'h1;   // identification register
    localparam logic [IR_W-1:0] CODE_SAMPLE_Z = 3'h2; // outputs forced high impedance
    localparam logic [IR_W-1:0] CODE_RESERVED_A = 3'h3; // reserved_code, acts as bypass
    localparam logic [IR_W-1:0] CODE_SAMPLE = 3'h4;   // sample / preload
    localparam logic [IR_W-1:0] CODE_PRIVATE = 3'h5;  // vendor_private_code, acts as bypass here
    localparam logic [IR_W-1:0] CODE_RESERVED_B = 3'h6; // reserved_code, acts as bypass
    localparam logic [IR_W-1:0] CODE_BYPASS = 3'h7;   // bypass register

    // ********************************
    // data register constants
    // ********************************
    localparam int ID_W = 32;                 // identification register width
    localparam logic BYPASS_CAPTURE = 1'h0;   // bypass cell loads zero on capture
    localparam logic CELL_DEFAULT = 1'h1;     // pinless scan cells load one

    // selected data register
    typedef enum logic [1:0] {
        TAPDEC_SEL_BYPASS,
        TAPDEC_SEL_BSR,
        TAPDEC_SEL_ID
    } tapdec_sel_t;

    // controller states
    typedef enum logic [3:0] {
        TAPDEC_RESET,
        TAPDEC_IDLE,
        TAPDEC_SEL_DR,
        TAPDEC_CAP_DR,
        TAPDEC_SHIFT_DR,
        TAPDEC_EXIT1_DR,
        TAPDEC_PAUSE_DR,
        TAPDEC_EXIT2_DR,
        TAPDEC_UPD_DR,
        TAPDEC_SEL_IR,
        TAPDEC_CAP_IR,
        TAPDEC_SHIFT_IR,
        TAPDEC_EXIT1_IR,
        TAPDEC_PAUSE_IR,
        TAPDEC_EXIT2_IR,
        TAPDEC_UPD_IR
    } tapdec_state_t;

endpackage

// [testbench/tapdec_ctl_model.sv]
// tapdec_ctl_model: behavioural boundary-scan test controller on the far side of the test link
// assumes: the bench calls its tasks one at a time from a single process
`timescale 1ns/1ps

module tapdec_ctl_model #(
    parameter real HALF_NS = 62.5 // half period of the test clock
)(
    // test link
    output logic tck_out,
    output logic tms_out,
    output logic tdi_out,
    input wire logic tdo_in
);
    // ************************************************
    // clock and idle levels
    // ************************************************
    // free running clock with an odd offset so its phase is unrelated to the system clock
    initial
    begin
        tms_out = 1'h1; // idle levels match the pull-ups on the pins
        tdi_out = 1'h1;
        tck_out = 1'h0;
        #17.3;
        forever #(HALF_NS) tck_out = ~tck_out;
    end

    // ************************************************
    // link tasks
    // ************************************************
    // one cycle: drive just after the falling edge, sample tdo at the rising edge
    task automatic step(input logic m, input logic d, output logic q);
        @(negedge tck_out);
        tms_out = m;
        tdi_out = d;
        @(posedge tck_out);
        q = tdo_in;
    endtask

    // five high mode-select edges reach reset from any state, then park in idle
    task automatic to_reset();
        logic q;
        repeat (5) step(1'h1, 1'h1, q);
        step(1'h0, 1'h1, q);
    endtask

    // full scan from idle and back; codes leave lsb first, so the leftmost digit is the msb
    task automatic scan(input logic ir, input int n, input logic [31:0] din, output logic [31:0] dout);
        logic q;
        dout = 32'h0;
        step(1'h1, 1'h1, q);
        if (ir)
        begin
            step(1'h1, 1'h1, q); // on to the instruction column
        end
        step(1'h0, 1'h1, q); // capture
        step(1'h0, 1'h1, q); // shift entered
        for (int i = 0; i < n; i++)
        begin
            step(i == n - 1, din[i], dout[i]);
        end
        step(1'h1, 1'h1, q); // update
        step(1'h0, 1'h1, q); // idle; the update falling edge has passed by now
    endtask
endmodule

// [testbench/tb_top.sv]
// tb_top: self-checking bench for the test access port instruction decoder
// assumes: tapdec_top and the controller model are compiled before it
`timescale 1ns/1ps

module tb_top;
    // ************************************************
    // settings and signals
    // ************************************************
    localparam logic [31:0] ID_CODE = 32'h0000_0001; // arbitrary identification value
    localparam logic [11:0] PINS = 12'ha5c; // pin levels held for the whole run
    localparam logic [31:0] BSR_CAP = {16'h0, 4'hf, PINS}; // pinless cells capture one
    localparam int LIMIT = 50000; // about fourteen times the expected run
    logic sys_clk_in;
    logic rst_in;
    logic tck;
    logic tms;
    logic tdi;
    logic tdo;
    logic tdo_oe_n;
    logic tdo_line; // serial line as the controller sees it
    logic [11:0] pin_state;
    logic hiz;
    logic drive;
    logic [7:0] mem_value;
    int error_cnt = 0;
    int total_checks = 0;
    int cycles = 0;

    // ************************************************
    // design and far side
    // ************************************************
    tapdec_top #(.BSR_W(16), .PIN_W(12), .OUT_W(8), .ID_CODE(ID_CODE)) uut (
        .sys_clk_in(sys_clk_in), .rst_in(rst_in), .tck_in(tck), .tms_in(tms), .tdi_in(tdi),
        .tdo_out(tdo), .tdo_oe_n_out(tdo_oe_n), .pin_state_in(pin_state),
        .mem_hiz_out(hiz), .mem_drive_out(drive), .mem_value_out(mem_value));
    tapdec_ctl_model ctl (.tck_out(tck), .tms_out(tms), .tdi_out(tdi), .tdo_in(tdo_line));

    // a released line shows the inverse, so a missing output enable corrupts every scan
    assign tdo_line = tdo_oe_n ? ~tdo : tdo;

    // system clock, 10 ns
    initial
    begin
        sys_clk_in = 1'h0;
        forever #5 sys_clk_in = ~sys_clk_in;
    end

    // hang guard: a run that overstays counts as a mismatch
    always @(posedge sys_clk_in)
    begin
        cycles++;
        if (cycles == LIMIT)
        begin
            error_cnt++;
            stop_test();
        end
    end

    // ************************************************
    // shared tasks
    // ************************************************
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic chk_mem(input logic h, input logic dr);
        chk("hiz", {31'h0, hiz}, {31'h0, h});
        chk("drive", {31'h0, drive}, {31'h0, dr});
    endtask

    // load an instruction; the flags cross to the system clock a few cycles after update
    task automatic load_ir(input logic [2:0] code);
        logic [31:0] d;
        ctl.scan(1'h1, 3, {29'h0, code}, d);
        chk("ir capture", {30'h0, d[1:0]}, 32'h1);
        repeat (4) @(negedge sys_clk_in);
    endtask

    task automatic stop_test();
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0)
        begin
            $display("Testbench passed");
        end
        else
        begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // ************************************************
    // scenarios
    // ************************************************
    // identification is active straight after power-up, bit 0 first
    task automatic t_ident();
        logic [31:0] d;
        chk("oe idle", {31'h0, tdo_oe_n}, 32'h1);
        ctl.scan(1'h0, 32, 32'h0, d);
        chk("id", d, ID_CODE);
        chk_mem(1'h0, 1'h0);
    endtask

    // every bypass-like code gives a one-bit path that captured zero
    task automatic t_bypass();
        logic [2:0] codes [4] = '{3'h7, 3'h3, 3'h6, 3'h5};
        logic [31:0] d;
        foreach (codes[i])
        begin
            load_ir(codes[i]);
            chk_mem(1'h0, 1'h0);
            ctl.scan(1'h0, 2, 32'h1, d);
            chk("bypass", d, 32'h2);
        end
        ctl.to_reset();
        ctl.scan(1'h0, 32, 32'h0, d);
        chk("id after reset", d, ID_CODE);
    endtask

    // sample capture, then high impedance with the boundary path still in place
    task automatic t_sample();
        logic [31:0] d;
        load_ir(3'h4);
        ctl.scan(1'h0, 16, 32'h0000_3c96, d);
        chk("sample capture", d, BSR_CAP);
        load_ir(3'h2);
        chk_mem(1'h1, 1'h0);
        ctl.scan(1'h0, 16, 32'h0000_3c96, d);
        chk("hiz path", d, BSR_CAP);
    endtask

    // preload a pattern, then extest drives it and captures the pins again
    task automatic t_extest();
        logic [31:0] d;
        load_ir(3'h4);
        ctl.scan(1'h0, 16, 32'h0000_5a69, d);
        chk_mem(1'h0, 1'h0);
        load_ir(3'h0);
        chk_mem(1'h0, 1'h1);
        chk("out cells", {24'h0, mem_value}, 32'h69);
        ctl.scan(1'h0, 16, 32'h0000_5a69, d);
        chk("extest capture", d, BSR_CAP);
        repeat (4) @(negedge sys_clk_in);
        chk("out cells kept", {24'h0, mem_value}, 32'h69);
    endtask

    // ************************************************
    // main sequence
    // ************************************************
    // reset is held long enough to pass the test-clock synchroniser
    initial
    begin
        rst_in = 1'h1;
        pin_state = PINS;
        repeat (40) @(negedge sys_clk_in);
        rst_in = 1'h0;
        repeat (3) @(posedge tck);
        ctl.to_reset();
        repeat (8) @(negedge sys_clk_in);
        t_ident();
        t_bypass();
        t_sample();
        t_extest();
        stop_test();
    end
endmodule
